// ==== verilog/srd_decoder.sv ====
// request decoder: frame check, dispatch, diagnostics, answer builder
//
// Overview of operation
// - accept 03h 04h 06h 10h 17h, 2Bh/0Dh
// - 08h/0Ah clears all diagnostic counters
// - 08h/0Bh..0Eh: bus, comm error, exception, server counts
// - 08h/0Fh..12h: no-response, NAK, busy, overrun counts
// - 65h dictionary read: 55h starts, AAh next
// - 66h object read: 55h starts, AAh next
// - read answer: byte count 2*M, then words
// - failure answer: code|80h, exception 01..04
// - single write echoes address, code, register, value
// - pdo reads aligned to four bytes
// - single writes to 6000h..6FFFh go to the pdo image
// - multi-byte fields most significant byte first
// - broadcast: act, never answer
// - eight data bits; stop bits follow parity
`timescale 1ns/1ps
`default_nettype none
module srd_decoder
    import srd_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  own_addr_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_end_i,
    input  wire logic        rx_crc_ok_i,
    input  wire logic        rx_overrun_i,
    output logic             reg_req_o,
    output logic             reg_we_o,
    output logic             reg_pdo_o,
    output logic [15:0]      reg_addr_o,
    output logic [15:0]      reg_wdata_o,
    input  wire logic        reg_ack_i,
    input  wire logic        reg_err_i,
    input  wire logic [15:0] reg_rdata_i,
    output logic             ext_stb_o,
    output logic [7:0]       ext_fc_o,
    output logic [7:0]       ext_sub_o,
    output logic             ext_bcast_o,
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i
);
    // ****
    // state
    // ****
    srd_state_t     state_ff,  nxt_state;
    logic [7:0]     hdr_ff [HDR_DEPTH], nxt_hdr [HDR_DEPTH];
    logic [7:0]     blen_ff,   nxt_blen;
    logic [7:0]     flen_ff,   nxt_flen;
    logic           bcast_ff,  nxt_bcast;
    logic [7:0]     resp_ff [6], nxt_resp [6];
    logic [7:0]     tlen_ff,   nxt_tlen;
    logic [7:0]     idx_ff,    nxt_idx;
    logic           rdrsp_ff,  nxt_rdrsp;
    logic [6:0]     ridx_ff,   nxt_ridx;
    logic [6:0]     rcnt_ff,   nxt_rcnt;
    logic           rerr_ff,   nxt_rerr;
    logic           stb_ff,    nxt_stb;
    logic [7:0]     efc_ff,    nxt_efc;
    logic [7:0]     esub_ff,   nxt_esub;
    logic [15:0]    rdbuf   [RD_DEPTH];
    logic [CNT_W-1:0] cnt_ff [CNT_NUM];
    logic [CNT_NUM-1:0] inc;
    logic           clr, in_pdo, buf_valid, buf_ready;
    logic [7:0]     fc, exc, buf_byte, k;
    logic [15:0]    fld_a, fld_b, word;
    logic [2:0]     sel;
    // request fields, most significant byte first
    assign fc     = hdr_ff[1];
    assign fld_a  = {hdr_ff[2], hdr_ff[3]};
    assign fld_b  = {hdr_ff[4], hdr_ff[5]};
    assign in_pdo = (fld_a >= PDO_BASE) && (fld_a <= PDO_LAST);
    // image access, held until acknowledged
    assign reg_req_o   = ce_i && (state_ff == ST_ACCESS);
    assign reg_we_o    = !rdrsp_ff;
    assign reg_pdo_o   = in_pdo;   // set for reads and writes whose first register lies in the pdo window
    assign reg_addr_o  = fld_a + {9'h000, ridx_ff};
    assign reg_wdata_o = fld_b;
    assign ext_stb_o   = stb_ff;
    assign ext_fc_o    = efc_ff;
    assign ext_sub_o   = esub_ff;
    assign ext_bcast_o = bcast_ff;

    // answer byte selection
    always_comb begin
        k        = idx_ff - RD_HDR_LEN;
        word     = rdbuf[k[7:1]];
        buf_byte = resp_ff[idx_ff[2:0]];
        if (rdrsp_ff && idx_ff >= RD_HDR_LEN) begin
            buf_byte = k[0] ? word[7:0] : word[15:8];
        end
        buf_valid = (state_ff == ST_SEND);
    end

    // ****
    // main sequencer
    // ****
    always_comb begin
        nxt_state = state_ff;
        nxt_hdr   = hdr_ff;
        nxt_blen  = blen_ff;
        nxt_flen  = flen_ff;
        nxt_bcast = bcast_ff;
        nxt_resp  = resp_ff;
        nxt_tlen  = tlen_ff;
        nxt_idx   = idx_ff;
        nxt_rdrsp = rdrsp_ff;
        nxt_ridx  = ridx_ff;
        nxt_rcnt  = rcnt_ff;
        nxt_rerr  = rerr_ff;
        nxt_stb   = 1'b0;
        nxt_efc   = efc_ff;
        nxt_esub  = esub_ff;
        inc       = '0;
        clr       = 1'b0;
        exc       = EXC_NONE;
        sel       = 3'h0;
        inc[CNT_OVERRUN] = rx_overrun_i;
        // frames ending while busy are counted and lost
        if (rx_end_i && state_ff != ST_IDLE) begin
            inc[CNT_BUS]  = 1'b1;
            inc[CNT_BUSY] = 1'b1;
        end
        unique case (state_ff)
            ST_IDLE: begin
                if (rx_valid_i && blen_ff != 8'hff) begin
                    if (blen_ff < HDR_DEPTH) begin
                        nxt_hdr[blen_ff[2:0]] = rx_data_i;
                    end
                    nxt_blen = blen_ff + 8'h01;
                end
                if (rx_end_i) begin
                    inc[CNT_BUS] = 1'b1;
                    nxt_blen     = 8'h00;
                    nxt_flen     = blen_ff;
                    if (!rx_crc_ok_i) begin
                        inc[CNT_COMM] = 1'b1;
                    end else if (hdr_ff[0] == own_addr_i ||
                                 hdr_ff[0] == BCAST_ADDR) begin
                        inc[CNT_SRV] = 1'b1;
                        nxt_bcast    = (hdr_ff[0] == BCAST_ADDR);
                        nxt_state    = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                nxt_resp[0] = own_addr_i;
                nxt_resp[1] = fc;
                for (int i = 2; i < 6; i++) begin
                    nxt_resp[i] = hdr_ff[i];
                end
                nxt_idx   = 8'h00;
                nxt_ridx  = 7'h00;
                nxt_rerr  = 1'b0;
                nxt_rdrsp = 1'b0;
                nxt_tlen  = LEN_ECHO;
                nxt_state = ST_SEND;
                unique case (fc)
                    FC_RD_HOLD, FC_RD_INPUT: begin
                        if (flen_ff != REQ_LEN || fld_b < RD_CNT_MIN ||
                            fld_b > RD_CNT_MAX) begin
                            exc = EXC_VALUE;
                        end else if (in_pdo &&
                                     (fld_a & PDO_ALIGN) != 16'h0000) begin
                            exc = EXC_ADDR;
                        end else begin
                            nxt_rdrsp   = 1'b1;
                            nxt_rcnt    = fld_b[6:0];
                            nxt_resp[2] = {fld_b[6:0], 1'b0};
                            nxt_tlen    = RD_HDR_LEN + {fld_b[6:0], 1'b0};
                            nxt_state   = ST_ACCESS;
                        end
                    end
                    FC_WR_SINGLE: begin
                        if (flen_ff != REQ_LEN) begin
                            exc = EXC_VALUE;
                        end else begin
                            nxt_state = ST_ACCESS;
                        end
                    end
                    FC_DIAG: begin
                        sel = 3'(hdr_ff[3] - SUB_CNT_LO);
                        if (flen_ff != REQ_LEN || hdr_ff[2] != 8'h00) begin
                            exc = EXC_VALUE;
                        end else if (hdr_ff[3] == SUB_CLEAR) begin
                            clr         = 1'b1;
                            nxt_resp[4] = 8'h00;
                            nxt_resp[5] = 8'h00;
                        end else if (hdr_ff[3] >= SUB_CNT_LO &&
                                     hdr_ff[3] <= SUB_CNT_HI) begin
                            nxt_resp[4] = cnt_ff[sel][15:8];
                            nxt_resp[5] = cnt_ff[sel][7:0];
                        end else begin
                            exc = EXC_FUNC;
                        end
                    end
                    FC_WR_MULTI, FC_RW_MULTI, FC_ENCAP,
                    FC_DICT_ALL, FC_DICT_OBJ: begin
                        if ((fc == FC_ENCAP && hdr_ff[2] != SUB_ENCAP) ||
                            ((fc == FC_DICT_ALL || fc == FC_DICT_OBJ) &&
                             hdr_ff[2] != SUB_START &&
                             hdr_ff[2] != SUB_NEXT)) begin
                            exc = EXC_FUNC;
                        end else begin
                            nxt_stb   = 1'b1;
                            nxt_efc   = fc;
                            nxt_esub  = hdr_ff[2];
                            nxt_state = ST_IDLE;
                        end
                    end
                    default: exc = EXC_FUNC;
                endcase
                if (exc != EXC_NONE) begin
                    nxt_rdrsp    = 1'b0;
                    nxt_resp[1]  = fc | EXC_FLAG;
                    nxt_resp[2]  = exc;
                    nxt_tlen     = LEN_EXC;
                    nxt_state    = ST_SEND;
                    inc[CNT_EXC] = 1'b1;
                end
                if (bcast_ff && nxt_state == ST_SEND) begin
                    inc[CNT_NORESP] = 1'b1;
                    nxt_state       = ST_IDLE;
                end
            end
            ST_ACCESS: begin
                if (reg_ack_i) begin
                    nxt_rerr = rerr_ff | reg_err_i;
                    nxt_ridx = ridx_ff + 7'h01;
                    if (!rdrsp_ff || nxt_ridx == rcnt_ff) begin
                        nxt_state = ST_SEND;
                        if (rerr_ff || reg_err_i) begin
                            nxt_rdrsp    = 1'b0;
                            nxt_resp[1]  = fc | EXC_FLAG;
                            nxt_resp[2]  = EXC_FAIL;
                            nxt_tlen     = LEN_EXC;
                            inc[CNT_EXC] = 1'b1;
                        end
                        if (bcast_ff) begin
                            inc[CNT_NORESP] = 1'b1;
                            nxt_state       = ST_IDLE;
                        end
                    end
                end
            end
            ST_SEND: begin
                if (buf_ready) begin
                    nxt_idx = idx_ff + 8'h01;
                    if (idx_ff == tlen_ff - 8'h01) begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            blen_ff  <= 8'h00;
            flen_ff  <= 8'h00;
            bcast_ff <= 1'b0;
            tlen_ff  <= 8'h00;
            idx_ff   <= 8'h00;
            rdrsp_ff <= 1'b0;
            ridx_ff  <= 7'h00;
            rcnt_ff  <= 7'h00;
            rerr_ff  <= 1'b0;
            stb_ff   <= 1'b0;
            efc_ff   <= 8'h00;
            esub_ff  <= 8'h00;
            hdr_ff   <= '{default: 8'h00};
            resp_ff  <= '{default: 8'h00};
        end else if (ce_i) begin
            state_ff <= nxt_state;
            blen_ff  <= nxt_blen;
            flen_ff  <= nxt_flen;
            bcast_ff <= nxt_bcast;
            tlen_ff  <= nxt_tlen;
            idx_ff   <= nxt_idx;
            rdrsp_ff <= nxt_rdrsp;
            ridx_ff  <= nxt_ridx;
            rcnt_ff  <= nxt_rcnt;
            rerr_ff  <= nxt_rerr;
            stb_ff   <= nxt_stb;
            efc_ff   <= nxt_efc;
            esub_ff  <= nxt_esub;
            hdr_ff   <= nxt_hdr;
            resp_ff  <= nxt_resp;
        end
    end
    // read words collected before the answer starts
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && state_ff == ST_ACCESS && reg_ack_i && rdrsp_ff) begin
            rdbuf[ridx_ff] <= reg_rdata_i;
        end
    end
    // ****
    // diagnostic counters, an event beats a clear
    // ****
    for (genvar g = 0; g < CNT_NUM; g++) begin : g_cnt
        logic [CNT_W-1:0] nxt_cnt;
        always_comb begin
            nxt_cnt = (clr ? '0 : cnt_ff[g]) + CNT_W'(inc[g]);
        end
        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                cnt_ff[g] <= '0;
            end else if (ce_i) begin
                cnt_ff[g] <= nxt_cnt;
            end
        end
    end

    // ****
    // transmit buffer
    // ****
    srd_buf2 u_buf (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (buf_valid),
        .in_data_i   ({idx_ff == tlen_ff - 8'h01, buf_byte}),
        .in_ready_o  (buf_ready),
        .out_valid_o (tx_valid_o),
        .out_data_o  ({tx_last_o, tx_data_o}),
        .out_ready_i (tx_ready_i)
    );
endmodule : srd_decoder
`default_nettype wire

// ==== verilog/srd_pkg.sv ====
// constants of the request decoder
package srd_pkg;
    // ****
    // function and subfunction codes
    // ****
    localparam logic [7:0] FC_RD_HOLD   = 8'h03;
    localparam logic [7:0] FC_RD_INPUT  = 8'h04;
    localparam logic [7:0] FC_WR_SINGLE = 8'h06;
    localparam logic [7:0] FC_DIAG      = 8'h08;
    localparam logic [7:0] FC_WR_MULTI  = 8'h10;
    localparam logic [7:0] FC_RW_MULTI  = 8'h17;
    localparam logic [7:0] FC_ENCAP     = 8'h2b;
    localparam logic [7:0] FC_DICT_ALL  = 8'h65;
    localparam logic [7:0] FC_DICT_OBJ  = 8'h66;
    localparam logic [7:0] SUB_CLEAR    = 8'h0a;
    localparam logic [7:0] SUB_CNT_LO   = 8'h0b;
    localparam logic [7:0] SUB_CNT_HI   = 8'h12;
    localparam logic [7:0] SUB_ENCAP    = 8'h0d;
    localparam logic [7:0] SUB_START    = 8'h55;
    localparam logic [7:0] SUB_NEXT     = 8'haa;
    // ****
    // exception answers
    // ****
    localparam logic [7:0] EXC_FLAG     = 8'h80;
    localparam logic [7:0] EXC_NONE     = 8'h00;
    localparam logic [7:0] EXC_FUNC     = 8'h01;
    localparam logic [7:0] EXC_ADDR     = 8'h02;
    localparam logic [7:0] EXC_VALUE    = 8'h03;
    localparam logic [7:0] EXC_FAIL     = 8'h04;
    // ****
    // frame layout and limits
    // ****
    localparam logic [7:0]  BCAST_ADDR  = 8'h00;
    localparam logic [7:0]  REQ_LEN     = 8'h06;
    localparam int          HDR_DEPTH   = 8;
    localparam logic [7:0]  LEN_EXC     = 8'h03;
    localparam logic [7:0]  LEN_ECHO    = 8'h06;
    localparam logic [7:0]  RD_HDR_LEN  = 8'h03;
    localparam logic [15:0] RD_CNT_MIN  = 16'h0001;
    localparam logic [15:0] RD_CNT_MAX  = 16'h007d;
    localparam int          RD_DEPTH    = 125;
    // pdo window, even register = 4-byte alignment
    localparam logic [15:0] PDO_BASE    = 16'h6000;
    localparam logic [15:0] PDO_LAST    = 16'h6fff;
    localparam logic [15:0] PDO_ALIGN   = 16'h0001;
    // ****
    // diagnostic counters
    // ****
    localparam int CNT_NUM     = 8;
    localparam int CNT_W       = 16;
    localparam int CNT_BUS     = 0;
    localparam int CNT_COMM    = 1;
    localparam int CNT_EXC     = 2;
    localparam int CNT_SRV     = 3;
    localparam int CNT_NORESP  = 4;
    localparam int CNT_NAK     = 5;
    localparam int CNT_BUSY    = 6;
    localparam int CNT_OVERRUN = 7;
    localparam int TX_W        = 9;

    typedef enum logic [2:0] {
        ST_IDLE, ST_EXEC, ST_ACCESS, ST_SEND
    } srd_state_t;
endpackage : srd_pkg

// ==== verilog/srd_buf2.sv ====
// two-entry transmit buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module srd_buf2
    import srd_pkg::*;
(
    input  wire logic            clk_sys_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic            in_valid_i,
    input  wire logic [TX_W-1:0] in_data_i,
    output logic                 in_ready_o,
    output logic                 out_valid_o,
    output logic [TX_W-1:0]      out_data_o,
    input  wire logic            out_ready_i
);
    logic [TX_W-1:0] mem_ff [2];
    logic            wptr_ff;
    logic            nxt_wptr;
    logic            rptr_ff;
    logic            nxt_rptr;
    logic [1:0]      cnt_ff;
    logic [1:0]      nxt_cnt;
    logic            push;
    logic            pop;

    // flags from the fill count
    assign in_ready_o  = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o  = mem_ff[rptr_ff];

    // pointer and count update
    always_comb begin
        push     = ce_i && in_valid_i && in_ready_o;
        pop      = ce_i && out_valid_o && out_ready_i;
        nxt_wptr = wptr_ff ^ push;
        nxt_rptr = rptr_ff ^ pop;
        nxt_cnt  = cnt_ff + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff  <= 2'h0;
        end else if (ce_i) begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff  <= nxt_cnt;
        end
    end

    // storage, written only on a push
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data_i;
        end
    end
endmodule : srd_buf2
`default_nettype wire

// ==== tb/srd_decoder_asserts.sv ====
// concurrent checks on the request decoder ports
`timescale 1ns/1ps
`default_nettype none
module srd_decoder_asserts (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  own_addr_i,
    input wire logic [7:0]  rx_data_i,
    input wire logic        rx_valid_i,
    input wire logic        rx_end_i,
    input wire logic        rx_crc_ok_i,
    input wire logic        reg_req_o,
    input wire logic        reg_we_o,
    input wire logic        reg_pdo_o,
    input wire logic [15:0] reg_addr_o,
    input wire logic        reg_ack_i,
    input wire logic        ext_stb_o,
    input wire logic [7:0]  ext_fc_o,
    input wire logic [7:0]  ext_sub_o,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_last_o,
    input wire logic        tx_ready_i
);
    logic [1:0] idx_ff;
    logic [7:0] sa_ff;
    logic [7:0] fc_ff;
    logic [7:0] sub_ff;
    // first three bytes of each frame
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || (ce_i && rx_end_i)) begin
            idx_ff <= 2'h0;
        end else if (ce_i && rx_valid_i && idx_ff != 2'h3) begin
            idx_ff <= idx_ff + 2'h1;
            case (idx_ff)
                2'h0: sa_ff <= rx_data_i;
                2'h1: fc_ff <= rx_data_i;
                default: sub_ff <= rx_data_i;
            endcase
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // no answer for eight cycles
    sequence s_quiet;
        !$rose(tx_valid_o) [*8];
    endsequence
    sequence s_pending;
        reg_req_o && !reg_ack_i && ce_i ##1 ce_i;
    endsequence
    req_hold_a:
    assert property (s_pending |-> reg_req_o) else $error("request dropped");
    tx_hold_a:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
        $stable(tx_data_o) && $stable(tx_last_o)) else $error("tx byte lost");
    stb_pulse_a:
    assert property (ext_stb_o |=> !ext_stb_o) else $error("strobe too long");
    stb_code_a:
    assert property (ext_stb_o |-> ext_fc_o == fc_ff && ext_sub_o == sub_ff
        && ext_fc_o inside {8'h10, 8'h17, 8'h2b, 8'h65, 8'h66})
        else $error("wrong dispatch code");
    stb_when_a:
    assert property (ext_stb_o && $past(ce_i) && $past(ce_i, 2)
        |-> $past(rx_end_i, 2)) else $error("dispatch at wrong time");
    bcast_quiet_a:
    assert property (ce_i && rx_end_i && sa_ff == 8'h00 |=> s_quiet)
        else $error("broadcast answered");
    drop_quiet_a:
    assert property (ce_i && rx_end_i && (!rx_crc_ok_i ||
        (sa_ff != own_addr_i && sa_ff != 8'h00)) |=> s_quiet)
        else $error("dropped frame answered");
    wr_kind_a:
    assert property (reg_req_o && reg_we_o |-> fc_ff == 8'h06)
        else $error("write without write code");
    rd_kind_a:
    assert property (reg_req_o && !reg_we_o |-> fc_ff inside {8'h03, 8'h04})
        else $error("read without read code");
    pdo_flag_a:
    assert property (reg_req_o |-> reg_pdo_o ==
        (reg_addr_o inside {[16'h6000:16'h6fff]})) else $error("bad pdo flag");
endmodule : srd_decoder_asserts
bind srd_decoder srd_decoder_asserts u_chk (.*);
`default_nettype wire

// ==== tb/srd_reg_model.sv ====
// register store model answering the decoder's access port
`timescale 1ns/1ps
`default_nettype none
module srd_reg_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic             ack_o,
    output logic             err_o,
    output logic [15:0]      rdata_o,
    output logic [15:0]      wr_addr_o,
    output logic [15:0]      wr_data_o
);
    logic [1:0]  wait_ff;
    logic [15:0] val_ff;
    // acks after one or three cycles; eexxh fails
    always_ff @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        if (rst_i || !req_i || ack_o) begin
            wait_ff <= 2'h0;
        end else if (wait_ff != (slow_i ? 2'h2 : 2'h0)) begin
            wait_ff <= wait_ff + 2'h1;
        end else begin
            ack_o <= 1'b1;
            val_ff <= addr_i ^ 16'ha5a5;
            err_o <= addr_i[15:8] == 8'hee;
            if (we_i && addr_i[15:8] != 8'hee) begin
                wr_addr_o <= addr_i;
                wr_data_o <= wdata_i;
            end
        end
    end
    // data scrambled off the ack cycle
    assign rdata_o = ack_o ? val_ff : ~val_ff;
endmodule : srd_reg_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the request decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import srd_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [7:0]  own_addr_i = 8'h05;
    logic [7:0]  rx_data_i = 8'h00;
    logic        rx_valid_i = 1'b0;
    logic        rx_end_i = 1'b0;
    logic        rx_crc_ok_i = 1'b0;
    logic        rx_overrun_i = 1'b0;
    logic        tx_ready_i = 1'b1;
    logic        slow = 1'b0;
    logic        stall = 1'b0;
    logic        reg_req_o, reg_we_o, reg_pdo_o, reg_ack_i, reg_err_i;
    logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i, wr_addr, wr_data;
    logic        ext_stb_o, ext_bcast_o, tx_valid_o, tx_last_o;
    logic [7:0]  ext_fc_o, ext_sub_o, tx_data_o;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    srd_decoder u_dut (.*);
    srd_reg_model u_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow),
        .req_i(reg_req_o), .we_i(reg_we_o), .addr_i(reg_addr_o),
        .wdata_i(reg_wdata_o), .ack_o(reg_ack_i), .err_o(reg_err_i),
        .rdata_o(reg_rdata_i), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    always #12.5 clk_sys_i = ~clk_sys_i;
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(string nm, logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one six-byte frame, then its end
    task automatic req(logic [7:0] sa, fc, logic [15:0] w1, w2, logic ok);
        logic [47:0] f;
        f = {sa, fc, w1, w2};
        for (int i = 5; i >= 0; i--) begin
            @(negedge clk_sys_i);
            rx_valid_i = 1'b1;
            rx_data_i = f[8*i +: 8];
        end
        @(negedge clk_sys_i);
        rx_valid_i = 1'b0;
        rx_end_i = 1'b1;
        rx_crc_ok_i = ok;
        @(negedge clk_sys_i);
        rx_end_i = 1'b0;
    endtask : req
    // takes one answer, checks length and bytes
    task automatic ans(string nm, logic [55:0] e, int len);
        logic [7:0] q[$];
        logic       done = 1'b0;
        for (int k = 0; k < 600 && !done; k++) begin
            @(negedge clk_sys_i);
            tx_ready_i = stall ? k[0] : 1'b1;
            if (tx_valid_o === 1'b1 && tx_ready_i) begin
                q.push_back(tx_data_o);
                done = tx_last_o;
            end
        end
        chk(nm, 16'(q.size()), 16'(len));
        for (int i = 0; i < len; i++)
            chk(nm, {8'h00, q[i]}, {8'h00, e[8*(len-1-i) +: 8]});
    endtask : ans
    task automatic quiet(string nm);
        int hits = 0;
        repeat (30) begin
            @(negedge clk_sys_i);
            hits += (tx_valid_o !== 1'b0);
        end
        chk(nm, 16'(hits), 16'h0000);
    endtask : quiet
    task automatic diag(logic [7:0] sub, logic [15:0] v);
        req(8'h05, FC_DIAG, {8'h00, sub}, 16'h0000, 1'b1);
        ans("diag", {8'h05, FC_DIAG, 8'h00, sub, v}, 6);
    endtask : diag
    // counters fill, then clear
    task automatic t_diag();
        req(8'h05, FC_RD_HOLD, 16'h0000, 16'h0001, 1'b0);
        quiet("crc drop");
        repeat (3) begin
            @(negedge clk_sys_i);
            rx_overrun_i = 1'b1;
            @(negedge clk_sys_i);
            rx_overrun_i = 1'b0;
        end
        req(8'h00, FC_WR_SINGLE, 16'h6004, 16'habcd, 1'b1);
        quiet("bcast");
        chk("bcast write", wr_addr, 16'h6004);
        chk("bcast flag", 16'(ext_bcast_o), 16'h0001);
        diag(8'h0c, 16'h0001);
        diag(8'h0f, 16'h0001);
        diag(8'h12, 16'h0003);
        diag(8'h0a, 16'h0000);
        for (int s = 8'h0b; s <= 8'h12; s++)
            diag(8'(s), 16'(s == 8'h0b ? 1 : s == 8'h0e ? 4 : 0));
    endtask : t_diag
    // stalled read, slow pdo read
    task automatic t_read();
        logic [15:0] r1, r2;
        r1 = 16'h1388 ^ 16'ha5a5;
        r2 = 16'h1389 ^ 16'ha5a5;
        stall = 1'b1;
        req(8'h05, FC_RD_HOLD, 16'h1388, 16'h0002, 1'b1);
        ans("rd hold", {8'h05, 8'h03, 8'h04, r1, r2}, 7);
        stall = 1'b0;
        slow = 1'b1;
        r1 = 16'h6000 ^ 16'ha5a5;
        req(8'h05, FC_RD_INPUT, 16'h6000, 16'h0001, 1'b1);
        ans("rd input", {8'h05, 8'h04, 8'h02, r1}, 5);
        slow = 1'b0;
        req(8'h07, FC_RD_HOLD, 16'h0000, 16'h0001, 1'b1);
        quiet("foreign");
    endtask : t_read
    task automatic t_write();
        req(8'h05, FC_WR_SINGLE, 16'h6002, 16'h1234, 1'b1);
        ce_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        ce_i = 1'b1;
        ans("wr echo", {8'h05, 8'h06, 16'h6002, 16'h1234}, 6);
        chk("wr addr", wr_addr, 16'h6002);
        chk("wr data", wr_data, 16'h1234);
    endtask : t_write
    // exception answers
    task automatic t_exc();
        logic [7:0]  fc [8] = '{8'h03, 8'h03, 8'h04, 8'h07, 8'h06, 8'h08,
                                8'h08, 8'h2b};
        logic [15:0] w1 [8] = '{16'h6001, 16'h0000, 16'h0000, 16'h0000,
                                16'hee00, 16'h0013, 16'h010b, 16'h0e00};
        logic [15:0] w2 [8] = '{16'h0001, 16'h0000, 16'h007e, 16'h0001,
                                16'h0001, 16'h0000, 16'h0000, 16'h0000};
        logic [7:0]  xc [8] = '{8'h02, 8'h03, 8'h03, 8'h01, 8'h04, 8'h01,
                                8'h03, 8'h01};
        for (int i = 0; i < 8; i++) begin
            req(8'h05, fc[i], w1[i], w2[i], 1'b1);
            ans("exception", {8'h05, fc[i] | 8'h80, xc[i]}, 3);
        end
    endtask : t_exc
    // dispatched codes
    task automatic t_ext();
        logic [7:0] fc [7] = '{8'h10, 8'h17, 8'h2b, 8'h65, 8'h65, 8'h66, 8'h66};
        logic [7:0] sb [7] = '{8'h00, 8'h00, 8'h0d, 8'h55, 8'haa, 8'h55, 8'haa};
        logic       seen;
        for (int i = 0; i < 7; i++) begin
            req(8'h05, fc[i], {sb[i], 8'h00}, 16'h0000, 1'b1);
            seen = 1'b0;
            for (int n = 0; n < 10 && !seen; n++) begin
                @(negedge clk_sys_i);
                seen = ext_stb_o === 1'b1;
            end
            chk("dispatch", 16'(seen), 16'h0001);
            chk("disp fc", {8'h00, ext_fc_o}, {8'h00, fc[i]});
            chk("disp sub", {8'h00, ext_sub_o}, {8'h00, sb[i]});
            repeat (10) @(negedge clk_sys_i);
        end
    endtask : t_ext
    // cuts a hung run short
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_diag();
        t_read();
        t_write();
        t_exc();
        t_ext();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
